// ---- shared/rtc_alarm_pkg.sv ----
// Constants and types shared by the alarm configuration block
package rtc_alarm_pkg;

    typedef logic [7:0] bcd_t;

    // Register byte addresses on the APB
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_VAL_HI = 8'h04;
    localparam logic [7:0] OFS_VAL_LO = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h10;

    // Configuration word layout
    localparam int BIT_ON = 15;
    localparam int BIT_PERP = 14;
    localparam int SEL_HI = 13;
    localparam int SEL_LO = 10;
    localparam int PTR_HI = 9;
    localparam int PTR_LO = 8;
    localparam int CNT_HI = 7;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam bcd_t VAL_RESET = 8'h00;

    // Interval codes
    localparam logic [3:0] SEL_HALF = 4'h0;
    localparam logic [3:0] SEL_SEC = 4'h1;
    localparam logic [3:0] SEL_TEN = 4'h2;
    localparam logic [3:0] SEL_MIN = 4'h3;
    localparam logic [3:0] SEL_HOUR = 4'h4;
    localparam logic [3:0] SEL_DAY = 4'h6;
    localparam logic [3:0] SEL_WEEK = 4'h7;
    localparam logic [3:0] SEL_MONTH = 4'h8;
    localparam logic [3:0] SEL_YEAR = 4'h9;
    localparam logic [3:0] SEL_GAP = 4'h5;

    // Window pointer codes
    localparam logic [1:0] PTR_0 = 2'h0;
    localparam logic [1:0] PTR_1 = 2'h1;
    localparam logic [1:0] PTR_NONE = 2'h3;

    // Repeat counter limits
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_FULL = 8'hFF;

    // Alarm value field indices
    localparam int NFIELD = 6;
    localparam logic [2:0] F_SEC = 3'h0;
    localparam logic [2:0] F_MIN = 3'h1;
    localparam logic [2:0] F_HOUR = 3'h2;
    localparam logic [2:0] F_WDAY = 3'h3;
    localparam logic [2:0] F_DAY = 3'h4;
    localparam logic [2:0] F_MON = 3'h5;

    // Leap-day alarm date, BCD
    localparam bcd_t FEB = 8'h02;
    localparam bcd_t DAY29 = 8'h29;

    // Interrupt status bits
    localparam int IRQ_W = 2;
    localparam int ST_EVENT = 0;
    localparam int ST_DONE = 1;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

endpackage

// ---- src/rtc_alarm_match.sv ----
// Compares the time fields chosen by the interval code with alarm values
`timescale 1ns/1ns
module rtc_alarm_match
    import rtc_alarm_pkg::*;
(
    input wire logic [3:0] interval_sel,
    input wire logic second_half,
    input wire logic leap_year,
    input wire bcd_t time_seconds,
    input wire bcd_t time_minutes,
    input wire bcd_t time_hours,
    input wire bcd_t time_weekday,
    input wire bcd_t time_day,
    input wire bcd_t time_month,
    input wire bcd_t alarm_seconds,
    input wire bcd_t alarm_minutes,
    input wire bcd_t alarm_hours,
    input wire bcd_t alarm_weekday,
    input wire bcd_t alarm_day,
    input wire bcd_t alarm_month,
    output logic match
);
    bcd_t now_f [NFIELD];
    bcd_t alm_f [NFIELD];
    logic [NFIELD-1:0] need;
    logic [NFIELD-1:0] fld_ok;
    logic code_ok;
    logic sec_ok;
    logic leap_ok;
    logic phase_ok;

    // Fields in index order for the compare loop
    assign now_f = '{time_seconds, time_minutes, time_hours,
                     time_weekday, time_day, time_month};
    assign alm_f = '{alarm_seconds, alarm_minutes, alarm_hours,
                     alarm_weekday, alarm_day, alarm_month};

    // Which fields each period must compare
    assign need[F_SEC] = interval_sel >= SEL_MIN;
    assign need[F_MIN] = interval_sel >= SEL_HOUR;
    assign need[F_HOUR] = interval_sel >= SEL_DAY;
    assign need[F_WDAY] = interval_sel == SEL_WEEK;
    assign need[F_DAY] = interval_sel >= SEL_MONTH;
    assign need[F_MON] = interval_sel == SEL_YEAR;

    // One comparator per field
    genvar gi;
    for (gi = 0; gi < NFIELD; gi++) begin : g_cmp
        assign fld_ok[gi] = !need[gi] || (now_f[gi] == alm_f[gi]);
    end

    // Reserved codes never match, guarding against misuse
    assign code_ok = (interval_sel <= SEL_YEAR) && (interval_sel != SEL_GAP);
    // Ten-second period looks at the units digit only
    assign sec_ok = (interval_sel == SEL_TEN) ?
                    (now_f[F_SEC][3:0] == alm_f[F_SEC][3:0]) : fld_ok[F_SEC];
    // All periods above half a second fire on the whole-second tick
    assign phase_ok = (interval_sel == SEL_HALF) || !second_half;
    // A Feb 29 yearly alarm waits for a leap year
    assign leap_ok = !(interval_sel == SEL_YEAR && alm_f[F_MON] == FEB &&
                       alm_f[F_DAY] == DAY29) || leap_year;
    assign match = code_ok && sec_ok && phase_ok && leap_ok && (&fld_ok[NFIELD-1:1]);

endmodule // rtc_alarm_match

// ---- src/rtc_alarm_cfg.sv ----
// Alarm configuration and repeat register block with APB access
`timescale 1ns/1ns
module rtc_alarm_cfg
    import rtc_alarm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic time_tick,
    input wire logic second_half,
    input wire logic leap_year,
    input wire bcd_t time_seconds,
    input wire bcd_t time_minutes,
    input wire bcd_t time_hours,
    input wire bcd_t time_weekday,
    input wire bcd_t time_day,
    input wire bcd_t time_month,
    output logic alarm_flag,
    output logic irq
);
    // Configuration state
    logic alarm_on;
    logic perpetual;
    logic [3:0] alarm_interval_sel;
    logic [1:0] alarm_value_window_ptr;
    logic [7:0] alarm_repeat_count;
    logic [15:0] cfg_word;
    bcd_t alarm_val [NFIELD];

    // Interrupt state
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;

    // Bus decode
    logic setup;
    logic access;
    logic hit_cfg;
    logic hit_hi;
    logic hit_lo;
    logic hit_st;
    logic hit_mask;
    logic hit_any;
    logic wr_acc;
    logic cfg_wr;
    logic hi_acc;
    logic hi_wr;
    logic lo_wr;
    logic got_data;

    // Window routing
    logic [2:0] hi_idx;
    logic [2:0] lo_idx;
    logic win_valid;
    bcd_t hi_byte;
    bcd_t lo_byte;
    logic [31:0] rd_mux;

    // Alarm engine
    logic match;
    logic alarm_event;
    logic cnt_zero;
    logic auto_off;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] next_status;
    logic next_on;
    logic [7:0] next_count;
    logic [1:0] next_ptr;

    // APB phases; ready waits until read data is caught for this transfer
    assign setup = psel && !penable;
    assign pready = clk_en && got_data; // A frozen setup edge costs one wait state
    assign access = psel && penable && pready;

    // Address decode
    assign hit_cfg = paddr == OFS_CFG;
    assign hit_hi = paddr == OFS_VAL_HI;
    assign hit_lo = paddr == OFS_VAL_LO;
    assign hit_st = paddr == OFS_STATUS;
    assign hit_mask = paddr == OFS_MASK;
    assign hit_any = hit_cfg || hit_hi || hit_lo || hit_st || hit_mask;
    assign wr_acc = access && pwrite && hit_any;
    assign cfg_wr = wr_acc && hit_cfg;
    assign hi_acc = access && hit_hi;
    assign hi_wr = wr_acc && hit_hi;
    assign lo_wr = wr_acc && hit_lo;

    // Packed view of the configuration word
    assign cfg_word = {alarm_on, perpetual, alarm_interval_sel,
                       alarm_value_window_ptr, alarm_repeat_count};

    // Pointer to field routing; code 11 reaches nothing
    assign win_valid = alarm_value_window_ptr != PTR_NONE;
    assign hi_idx = (alarm_value_window_ptr == PTR_0) ? F_MIN :
                    (alarm_value_window_ptr == PTR_1) ? F_WDAY : F_MON;
    assign lo_idx = (alarm_value_window_ptr == PTR_0) ? F_SEC :
                    (alarm_value_window_ptr == PTR_1) ? F_HOUR : F_DAY;
    assign hi_byte = win_valid ? alarm_val[hi_idx] : VAL_RESET;
    assign lo_byte = win_valid ? alarm_val[lo_idx] : VAL_RESET;

    // Read data select; upper bits read as zero
    assign rd_mux = hit_cfg ? {16'h0000, cfg_word} :
                    hit_hi ? {24'h000000, hi_byte} :
                    hit_lo ? {24'h000000, lo_byte} :
                    hit_st ? {30'h00000000, irq_status} :
                    hit_mask ? {30'h00000000, irq_mask} : 32'h00000000;

    // Read data and error are caught in the first enabled cycle of a transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            got_data <= 1'b0;
        end else if (clk_en) begin
            got_data <= psel && !pready;
            if (psel && !got_data) begin
                prdata <= pwrite ? 32'h00000000 : rd_mux;
                pslverr <= !hit_any;
            end
        end
    end

    // Alarm value storage, one byte per field
    genvar gi;
    for (gi = 0; gi < NFIELD; gi++) begin : g_val
        logic fld_wr;
        assign fld_wr = win_valid && ((hi_wr && hi_idx == 3'(gi)) ||
                                      (lo_wr && lo_idx == 3'(gi)));
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                alarm_val[gi] <= VAL_RESET;
            end else if (clk_en && fld_wr) begin
                alarm_val[gi] <= pwdata[7:0];
            end
        end
    end

    // Field comparison against the live time
    rtc_alarm_match u_match (
        .interval_sel(alarm_interval_sel),
        .second_half(second_half),
        .leap_year(leap_year),
        .time_seconds(time_seconds),
        .time_minutes(time_minutes),
        .time_hours(time_hours),
        .time_weekday(time_weekday),
        .time_day(time_day),
        .time_month(time_month),
        .alarm_seconds(alarm_val[F_SEC]),
        .alarm_minutes(alarm_val[F_MIN]),
        .alarm_hours(alarm_val[F_HOUR]),
        .alarm_weekday(alarm_val[F_WDAY]),
        .alarm_day(alarm_val[F_DAY]),
        .alarm_month(alarm_val[F_MON]),
        .match(match)
    );

    // Event only on a tick, so one match fires once
    assign alarm_event = clk_en && alarm_on && time_tick && match;
    assign cnt_zero = alarm_repeat_count == CNT_ZERO;
    assign auto_off = alarm_event && cnt_zero && !perpetual;

    // Next config values; a software write beats a same-cycle event
    assign next_on = cfg_wr ? pwdata[BIT_ON] : (alarm_on && !auto_off);
    assign next_count = cfg_wr ? pwdata[CNT_HI:0] :
                        !alarm_event ? alarm_repeat_count :
                        !cnt_zero ? alarm_repeat_count - 8'h01 :
                        perpetual ? CNT_FULL : CNT_ZERO;
    assign next_ptr = cfg_wr ? pwdata[PTR_HI:PTR_LO] :
                      (hi_acc && alarm_value_window_ptr != PTR_0) ?
                      alarm_value_window_ptr - 2'h1 : alarm_value_window_ptr;

    // Configuration register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {alarm_on, perpetual, alarm_interval_sel} <= CFG_RESET[BIT_ON:SEL_LO];
            alarm_value_window_ptr <= CFG_RESET[PTR_HI:PTR_LO];
            alarm_repeat_count <= CFG_RESET[CNT_HI:0];
        end else if (clk_en) begin
            alarm_on <= next_on;
            alarm_repeat_count <= next_count;
            alarm_value_window_ptr <= next_ptr;
            if (cfg_wr) begin
                perpetual <= pwdata[BIT_PERP];
                alarm_interval_sel <= pwdata[SEL_HI:SEL_LO];
            end
        end
    end

    // One-cycle flag toward outer interrupt logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_flag <= 1'b0;
        end else if (clk_en) begin
            alarm_flag <= alarm_event;
        end
    end

    // Sticky status; a set in the clearing cycle wins
    assign irq_set = {auto_off, alarm_event};
    assign irq_clr = (wr_acc && hit_st) ? pwdata[IRQ_W-1:0] : IRQ_RESET;
    assign next_status = (irq_status & ~irq_clr) | irq_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
        end else if (clk_en) begin
            irq_status <= next_status;
            if (wr_acc && hit_mask) begin
                irq_mask <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // Level interrupt while any unmasked bit stands
    assign irq = |(irq_status & irq_mask);

    // Checks on the block's own behaviour
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    cfg_write_a:
    assert property (cfg_wr && !time_tick |=> cfg_word == $past(pwdata[15:0]))
        else $error("config write not stored");

    cfg_read_a:
    assert property (clk_en && setup && !pwrite && hit_cfg
                     |=> prdata == {16'h0000, $past(cfg_word)})
        else $error("config read mismatch");

    auto_off_a:
    assert property (auto_off && !cfg_wr |=> !alarm_on && irq_status[ST_DONE])
        else $error("enable not cleared");

    count_wrap_a:
    assert property (alarm_event && cnt_zero && !cfg_wr
                     |=> alarm_repeat_count == ($past(perpetual) ? CNT_FULL : CNT_ZERO))
        else $error("count wrap or hold wrong");

    count_dec_a:
    assert property (alarm_event && !cnt_zero && !cfg_wr
                     |=> alarm_repeat_count == $past(alarm_repeat_count) - 8'h01)
        else $error("count not decremented");

    count_still_a:
    assert property (clk_en && !alarm_event && !cfg_wr |=> $stable(alarm_repeat_count))
        else $error("count moved without event");

    half_sec_a:
    assert property (alarm_interval_sel == SEL_SEC && second_half |-> !match)
        else $error("second alarm on half tick");

    leap_day_a:
    assert property (alarm_interval_sel == SEL_YEAR && alarm_val[F_MON] == FEB &&
                     alarm_val[F_DAY] == DAY29 && !leap_year |-> !match)
        else $error("leap-day alarm off leap year");

    window_none_a:
    assert property (clk_en && setup && !pwrite && hit_hi &&
                     alarm_value_window_ptr == PTR_NONE |=> prdata == 32'h00000000)
        else $error("unused window not zero");

    ptr_step_a:
    assert property (hi_acc && !cfg_wr |=> alarm_value_window_ptr ==
                     ($past(alarm_value_window_ptr) == PTR_0 ? PTR_0 :
                      $past(alarm_value_window_ptr) - 2'h1))
        else $error("pointer step wrong");

    event_gate_a:
    assert property (alarm_flag && $past(clk_en) |-> $past(alarm_on && time_tick && match))
        else $error("event without cause");

    flag_pulse_a:
    assert property (clk_en |=> alarm_flag == $past(alarm_event))
        else $error("flag not tied to event");

    status_set_a:
    assert property (alarm_event |=> irq_status[ST_EVENT])
        else $error("event status not set");

    win_hi_a:
    assert property (hi_wr && alarm_value_window_ptr == PTR_0
                     |=> alarm_val[F_MIN] == $past(pwdata[7:0]))
        else $error("minutes byte not written");

    win_lo_a:
    assert property (lo_wr && alarm_value_window_ptr == PTR_1
                     |=> alarm_val[F_HOUR] == $past(pwdata[7:0]))
        else $error("hours byte not written");

    zero_wait_a:
    assert property (clk_en && setup |=> pready || !clk_en)
        else $error("wait state with clock enabled");

    frozen_a:
    assert property (!clk_en |=> $stable(cfg_word) && $stable(irq_status) && $stable(prdata))
        else $error("state moved while frozen");

    bad_addr_a:
    assert property (clk_en && setup && !hit_any |=> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");

    write_data_a:
    assert property (clk_en && setup && pwrite |=> prdata == 32'h00000000)
        else $error("write returned read data");

    ten_sec_a:
    assert property (alarm_interval_sel == SEL_TEN &&
                     time_seconds[3:0] != alarm_val[F_SEC][3:0] |-> !match)
        else $error("ten-second alarm off its digit");

    reserved_a:
    assert property (alarm_interval_sel > SEL_YEAR || alarm_interval_sel == SEL_GAP |-> !match)
        else $error("reserved interval matched");

    // Main scenarios
    wrap_c: cover property (alarm_event && cnt_zero && perpetual);
    off_c: cover property (auto_off ##[1:20] irq);
    walk_c: cover property (hi_acc ##[1:10] hi_acc ##[1:10] hi_acc);
    set_clr_c: cover property (alarm_event && wr_acc && hit_st && pwdata[ST_EVENT]);
    freeze_c: cover property (psel && !penable && !clk_en ##1 psel && penable);

endmodule // rtc_alarm_cfg

// ---- test/test_rtc_alarm_cfg.sv ----
// Self-checking bench for the alarm configuration and repeat block
`timescale 1ns/1ns
module test_rtc_alarm_cfg import rtc_alarm_pkg::*; ();
    logic pclk, presetn, clk_en, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, time_tick, second_half, leap_year, alarm_flag, irq;
    bcd_t time_seconds, time_minutes, time_hours, time_weekday, time_day, time_month;
    int bad_count = 0;
    int n_checks = 0;
    int flag_count = 0;
    integer seed = 58;
    logic [32:0] exp_q[$];
    logic [3:0] codes[9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9};
    logic [7:0] regs[5] = '{OFS_CFG, OFS_VAL_HI, OFS_VAL_LO, OFS_STATUS, OFS_MASK};
    logic flag_prev = 1'b0;

    rtc_alarm_cfg i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .time_tick(time_tick), .second_half(second_half),
        .leap_year(leap_year), .time_seconds(time_seconds), .time_minutes(time_minutes),
        .time_hours(time_hours), .time_weekday(time_weekday), .time_day(time_day),
        .time_month(time_month), .alarm_flag(alarm_flag), .irq(irq));

    // Free-running bus clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Monitor: every completed transfer is matched to the oldest note
    always @(posedge pclk) begin
        if (presetn && psel && penable && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(33'h1FFFFFFFF, 33'h0, "transfer with no expectation");
            end else begin
                check({pslverr, prdata}, exp_q.pop_front(), "apb response");
            end
        end
    end

    // Alarm flag must never stand two cycles in a row
    always @(posedge pclk) begin
        if (alarm_flag === 1'b1) begin
            flag_count++;
        end
        if (presetn && alarm_flag === 1'b1 && flag_prev === 1'b1) begin
            check(33'h1, 33'h0, "alarm flag longer than a cycle");
        end
        flag_prev = alarm_flag;
    end

    // Setup, then access held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] exp);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        exp_q.push_back(exp);
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, {1'b0, exp});
    endtask

    function automatic logic [31:0] cfgw(input logic on, input logic perp, input logic [3:0] sel,
                                         input logic [1:0] ptr, input logic [7:0] cnt);
        return {16'h0000, on, perp, sel, ptr, cnt};
    endfunction

    // One time step; counts alarm flag pulses that follow it
    task automatic tick(input logic half, input int fire);
        int n0;
        n0 = flag_count;
        @(posedge pclk);
        second_half <= half;
        time_tick <= 1'b1;
        @(posedge pclk);
        time_tick <= 1'b0;
        repeat (3) @(posedge pclk);
        check(33'(flag_count - n0), 33'(fire), "alarm flag pulses");
    endtask

    // Bound on the whole run, far above the expected length
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        $display("BAD %0t watchdog expired", $time);
        end_of_test();
    end

    initial begin
        logic [31:0] r, d;
        {presetn, clk_en, psel, penable, pwrite, time_tick, second_half, leap_year} = 8'h40;
        {paddr, pwdata} = '0;
        {time_seconds, time_minutes, time_hours} = {8'h45, 8'h30, 8'h07};
        {time_weekday, time_day, time_month} = {8'h03, 8'h15, 8'h12};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values of every register
        foreach (regs[k]) begin
            rd(regs[k], 32'h0);
        end
        // Random read-back of the config fields, enable held low; only legal interval codes
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            d = cfgw(1'b0, r[14], codes[r[19:16] % 9], r[9:8], r[7:0]);
            wr(OFS_CFG, d);
            rd(OFS_CFG, d);
        end
        // Unmapped address is refused
        apb(1'b1, 8'h14, 32'h0000005A, 33'h100000000);
        apb(1'b0, 8'h14, 32'h0, 33'h100000000);
        // Window routing and pointer stepping, code 11 selects nothing
        wr(OFS_CFG, cfgw(0, 0, 4'h0, PTR_NONE, 8'h00));
        wr(OFS_VAL_HI, 32'h000000AA);
        rd(OFS_CFG, cfgw(0, 0, 4'h0, 2'h2, 8'h00));
        wr(OFS_VAL_LO, 32'h00000015);
        wr(OFS_VAL_HI, 32'h00000012);
        wr(OFS_VAL_LO, 32'h00000007);
        wr(OFS_VAL_HI, 32'h00000003);
        wr(OFS_VAL_LO, 32'h00000045);
        wr(OFS_VAL_HI, 32'h00000030);
        rd(OFS_CFG, 32'h0);
        wr(OFS_CFG, cfgw(0, 0, 4'h0, PTR_NONE, 8'h00));
        rd(OFS_VAL_HI, 32'h0);
        rd(OFS_VAL_LO, 32'h15);
        rd(OFS_VAL_HI, 32'h12);
        rd(OFS_VAL_LO, 32'h07);
        rd(OFS_VAL_HI, 32'h03);
        rd(OFS_VAL_LO, 32'h45);
        rd(OFS_VAL_HI, 32'h30);
        rd(OFS_VAL_HI, 32'h30);
        // Setup edge frozen by a low clock enable; read must still bring fresh data
        fork
            rd(OFS_CFG, 32'h0);
            begin
                repeat (1) @(posedge pclk);
                clk_en <= 1'b0;
                repeat (3) @(posedge pclk);
                clk_en <= 1'b1;
            end
        join
        // Every interval code with all fields matching; reserved 0101 never fires
        for (int c = 0; c < 10; c++) begin
            wr(OFS_CFG, cfgw(1, 1, c[3:0], 2'h0, 8'h05));
            tick(1'b0, c != 5);
            rd(OFS_CFG, cfgw(1, 1, c[3:0], 2'h0, (c != 5) ? 8'h04 : 8'h05));
        end
        // Half-second mode fires in the second half, yearly mode does not
        tick(1'b1, 0);
        wr(OFS_CFG, cfgw(1, 0, SEL_HALF, 2'h0, 8'h05));
        tick(1'b1, 1);
        // Ten-second mode looks at the units digit of the seconds only
        wr(OFS_CFG, cfgw(1, 0, SEL_TEN, 2'h0, 8'h05));
        time_seconds <= 8'h35;
        tick(1'b0, 1);
        time_seconds <= 8'h46;
        tick(1'b0, 0);
        time_seconds <= 8'h45;
        // Hour mode ignores hours but compares minutes
        wr(OFS_CFG, cfgw(1, 0, SEL_HOUR, 2'h0, 8'h05));
        time_hours <= 8'h11;
        tick(1'b0, 1);
        time_minutes <= 8'h31;
        tick(1'b0, 0);
        {time_hours, time_minutes} <= {8'h07, 8'h30};
        // Count runs out, then enable clears itself
        wr(OFS_MASK, 32'h3);
        wr(OFS_CFG, cfgw(1, 0, SEL_MIN, 2'h0, 8'h02));
        tick(1'b0, 1);
        tick(1'b0, 1);
        rd(OFS_CFG, cfgw(1, 0, SEL_MIN, 2'h0, 8'h00));
        tick(1'b0, 1);
        rd(OFS_CFG, cfgw(0, 0, SEL_MIN, 2'h0, 8'h00));
        tick(1'b0, 0);
        rd(OFS_STATUS, 32'h3);
        @(negedge pclk);
        check({32'h0, irq}, 33'h1, "irq with pending status");
        wr(OFS_STATUS, 32'h1);
        rd(OFS_STATUS, 32'h2);
        wr(OFS_MASK, 32'h1);
        @(negedge pclk);
        check({32'h0, irq}, 33'h0, "irq with bit masked");
        wr(OFS_STATUS, 32'h2);
        rd(OFS_STATUS, 32'h0);
        // Perpetual repeat wraps the count from zero
        wr(OFS_CFG, cfgw(1, 1, SEL_MIN, 2'h0, 8'h00));
        tick(1'b0, 1);
        rd(OFS_CFG, cfgw(1, 1, SEL_MIN, 2'h0, 8'hFF));
        // Leap-day yearly alarm only in a leap year
        wr(OFS_CFG, cfgw(0, 0, 4'h0, 2'h2, 8'h00));
        wr(OFS_VAL_LO, 32'h00000029);
        wr(OFS_VAL_HI, 32'h00000002);
        {time_day, time_month} <= {DAY29, FEB};
        wr(OFS_CFG, cfgw(1, 0, SEL_YEAR, 2'h0, 8'h05));
        tick(1'b0, 0);
        leap_year <= 1'b1;
        tick(1'b0, 1);
        rd(OFS_CFG, cfgw(1, 0, SEL_YEAR, 2'h0, 8'h04));
        repeat (4) @(posedge pclk);
        end_of_test();
    end
endmodule // test_rtc_alarm_cfg
